// ==== core/wdog_pkg.sv ====
// constants, types and register map of the current gated window watchdog
// assumes a single 40 MHz clock and classic wishbone register access
package wdog_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// window times in ms, stand-ins for the capacitor timing
	localparam int unsigned TIMEOUT_MS = 40;
	localparam int unsigned DPULSE_MS = 10;
	localparam int unsigned HOLD_MS = 20;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned DPULSE_CYC = DPULSE_MS * CYC_PER_MS;
	localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;

	// register byte addresses
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_MASK = 8'h04;
	localparam logic [7:0] A_STATE = 8'h08;
	localparam logic [7:0] A_TIMEOUT = 8'h0C;
	localparam logic [7:0] A_DPULSE = 8'h10;
	localparam logic [7:0] A_HOLD = 8'h14;

	// event bits of status and mask
	localparam int unsigned NEV = 4;
	localparam int unsigned EV_FAULT = 0;
	localparam int unsigned EV_TRIG = 1;
	localparam int unsigned EV_ON = 2;
	localparam int unsigned EV_OFF = 3;
	localparam logic [NEV-1:0] EV_NONE = 4'h0;

	// state register fields
	localparam int unsigned F_MON = 4;
	localparam int unsigned F_WO = 5;
	localparam int unsigned F_UV = 6;

	// pin struct bit count, all pins synchronised together
	localparam int unsigned NPIN = 6;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_OPEN = 4'h2,
		ST_CLOSED = 4'h4,
		ST_FAULT = 4'h8
	} wd_state_e;

	typedef struct packed {
		logic trigger_input;
		logic adjust_low;
		logic adjust_high;
		logic cur_at_activation;
		logic cur_at_deactivation;
		logic undervoltage;
	} pins_s;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;
endpackage : wdog_pkg

// ==== core/current_gated_window_watchdog.sv ====
// window watchdog gated by a load current detector with hysteresis
// assumes asynchronous pin levels from the analog front end and a wishbone master
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module current_gated_window_watchdog #(
	parameter logic [31:0] TIMEOUT_CYC_P = 32'(wdog_pkg::TIMEOUT_CYC),
	parameter logic [31:0] DPULSE_CYC_P = 32'(wdog_pkg::DPULSE_CYC),
	parameter logic [31:0] HOLD_CYC_P = 32'(wdog_pkg::HOLD_CYC)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// asynchronous pin levels
	input wire wdog_pkg::pins_s pins_i,
	// wishbone slave
	input wire wdog_pkg::wb_req_s wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// pin outputs and interrupt
	output logic watchdog_fault_out_o,
	output logic undervoltage_reset_out_o,
	output logic combined_fault_reset_out_o,
	output logic irq_o
);
	import wdog_pkg::*;

	// three stage synchronisers; reset to zero models the trigger pull-down
	logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
	pins_s pin;
	logic trig_prev_q;
	logic rise;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_filt
			assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			flt_q <= '0;
			trig_prev_q <= 1'b0;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
			trig_prev_q <= pin.trigger_input;
		end
	end

	assign pin = pins_s'(flt_q);
	assign rise = pin.trigger_input & ~trig_prev_q;

	// comparator hysteresis and monitoring decision
	logic hyst_q, hyst_d;
	logic mon;

	always_comb begin
		hyst_d = hyst_q;
		if (pin.cur_at_activation) begin
			hyst_d = 1'b1;
		end else if (pin.cur_at_deactivation) begin
			hyst_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hyst_q <= 1'b0;
		end else begin
			hyst_q <= hyst_d;
		end
	end

	// tied low wins over tied high if both ever show
	assign mon = ~pin.undervoltage & ~pin.adjust_low
		& (pin.adjust_high | hyst_q);

	// watchdog state machine
	wd_state_e st_q, st_d;
	logic [31:0] to_q, to_d, win_q, win_d;
	logic [31:0] to_lim_q, dp_lim_q, hold_lim_q;
	logic [NEV-1:0] ev;
	logic to_done, dp_done, hold_done;

	// plus one compare avoids underflow when a limit is written as zero
	assign to_done = (to_q + 32'h1) >= to_lim_q;
	assign dp_done = (win_q + 32'h1) >= dp_lim_q;
	assign hold_done = (win_q + 32'h1) >= hold_lim_q;

	always_comb begin
		st_d = st_q;
		to_d = to_q;
		win_d = win_q;
		ev = EV_NONE;
		if (pin.undervoltage) begin
			st_d = ST_IDLE;
			to_d = '0;
			win_d = '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (mon) begin
						st_d = ST_OPEN;
						to_d = '0;
						win_d = '0;
						ev[EV_ON] = 1'b1;
					end
				end
				ST_OPEN: begin
					if (!mon) begin
						st_d = ST_IDLE;
						to_d = '0;
						win_d = '0;
						ev[EV_OFF] = 1'b1;
					end else if (rise) begin
						st_d = ST_CLOSED;
						to_d = '0;
						win_d = '0;
						ev[EV_TRIG] = 1'b1;
					end else if (to_done) begin
						st_d = ST_FAULT;
						win_d = '0;
						ev[EV_FAULT] = 1'b1;
					end else begin
						to_d = to_q + 32'h1;
					end
				end
				ST_CLOSED: begin
					if (!mon) begin
						st_d = ST_IDLE;
						to_d = '0;
						win_d = '0;
						ev[EV_OFF] = 1'b1;
					end else if (rise || to_done) begin
						st_d = ST_FAULT;
						win_d = '0;
						ev[EV_FAULT] = 1'b1;
						ev[EV_TRIG] = rise;
					end else begin
						to_d = to_q + 32'h1;
						if (dp_done) begin
							st_d = ST_OPEN;
						end else begin
							win_d = win_q + 32'h1;
						end
					end
				end
				ST_FAULT: begin
					// edges here are ignored, mon loss does not shorten the hold
					if (hold_done) begin
						st_d = mon ? ST_OPEN : ST_IDLE;
						to_d = '0;
						win_d = '0;
						ev[EV_ON] = mon;
					end else begin
						win_d = win_q + 32'h1;
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end

	logic wo_q, ruv_q, comb_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			to_q <= '0;
			win_q <= '0;
			wo_q <= 1'b1;
			ruv_q <= 1'b1;
			comb_q <= 1'b1;
		end else begin
			st_q <= st_d;
			to_q <= to_d;
			win_q <= win_d;
			wo_q <= st_d != ST_FAULT;
			ruv_q <= ~pin.undervoltage;
			comb_q <= (st_d != ST_FAULT) & ~pin.undervoltage;
		end
	end

	// wishbone registers and interrupt
	logic [NEV-1:0] sts_q, sts_d, msk_q, msk_d;
	logic [31:0] to_lim_d, dp_lim_d, hold_lim_d, dat_d, dat_q;
	logic ack_q, hit, wr, irq_q;

	function automatic logic at(input logic [7:0] adr, input logic [7:0] off);
		at = adr == off;
	endfunction : at

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction : merge

	assign hit = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
	assign wr = hit & wb_req_i.we;

	always_comb begin
		logic [31:0] cl;
		logic [31:0] mm;
		cl = '0;
		mm = '0;
		msk_d = msk_q;
		to_lim_d = to_lim_q;
		dp_lim_d = dp_lim_q;
		hold_lim_d = hold_lim_q;
		if (wr && at(wb_req_i.adr, A_STATUS)) begin
			cl = merge(32'h0, wb_req_i.dat, wb_req_i.sel);
		end else if (wr && at(wb_req_i.adr, A_MASK)) begin
			mm = merge({28'h0, msk_q}, wb_req_i.dat, wb_req_i.sel);
			msk_d = mm[NEV-1:0];
		end else if (wr && at(wb_req_i.adr, A_TIMEOUT)) begin
			to_lim_d = merge(to_lim_q, wb_req_i.dat, wb_req_i.sel);
		end else if (wr && at(wb_req_i.adr, A_DPULSE)) begin
			dp_lim_d = merge(dp_lim_q, wb_req_i.dat, wb_req_i.sel);
		end else if (wr && at(wb_req_i.adr, A_HOLD)) begin
			hold_lim_d = merge(hold_lim_q, wb_req_i.dat, wb_req_i.sel);
		end
		// a new event beats a write-one clear in the same cycle
		sts_d = (sts_q & ~cl[NEV-1:0]) | ev;
		dat_d = '0;
		if (at(wb_req_i.adr, A_STATUS)) begin
			dat_d = {28'h0, sts_q};
		end else if (at(wb_req_i.adr, A_MASK)) begin
			dat_d = {28'h0, msk_q};
		end else if (at(wb_req_i.adr, A_STATE)) begin
			dat_d = {25'h0, ruv_q, wo_q, mon, st_q};
		end else if (at(wb_req_i.adr, A_TIMEOUT)) begin
			dat_d = to_lim_q;
		end else if (at(wb_req_i.adr, A_DPULSE)) begin
			dat_d = dp_lim_q;
		end else if (at(wb_req_i.adr, A_HOLD)) begin
			dat_d = hold_lim_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sts_q <= EV_NONE;
			msk_q <= EV_NONE;
			to_lim_q <= TIMEOUT_CYC_P;
			dp_lim_q <= DPULSE_CYC_P;
			hold_lim_q <= HOLD_CYC_P;
			ack_q <= 1'b0;
			dat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			sts_q <= sts_d;
			msk_q <= msk_d;
			to_lim_q <= to_lim_d;
			dp_lim_q <= dp_lim_d;
			hold_lim_q <= hold_lim_d;
			ack_q <= hit;
			dat_q <= hit ? dat_d : 32'h0;
			irq_q <= |(sts_d & msk_d);
		end
	end

	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign watchdog_fault_out_o = wo_q;
	assign undervoltage_reset_out_o = ruv_q;
	assign combined_fault_reset_out_o = comb_q;
	assign irq_o = irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_act_on;
		st_q == ST_IDLE && pin.cur_at_activation && !pin.adjust_low && !pin.undervoltage
			|=> ##1 st_q == ST_OPEN;
	endproperty
	a_act_on: assert property (p_act_on) else $error("no start at activation");

	property p_band;
		!hyst_q && !pin.cur_at_activation |=> !hyst_q;
	endproperty
	a_band: assert property (p_band) else $error("left band early");

	property p_unused;
		pin.adjust_low && st_q == ST_IDLE |=> st_q == ST_IDLE;
	endproperty
	a_unused: assert property (p_unused) else $error("monitoring while unused");

	property p_always;
		pin.adjust_high && !pin.adjust_low && !pin.undervoltage && st_q == ST_IDLE
			|=> st_q == ST_OPEN;
	endproperty
	a_always: assert property (p_always) else $error("tied high not active");

	property p_level;
		st_q == ST_OPEN && mon && !rise && !to_done |=> st_q == ST_OPEN;
	endproperty
	a_level: assert property (p_level) else $error("non-edge taken");

	property p_ignore;
		st_q == ST_FAULT && !hold_done && !pin.undervoltage |=> st_q == ST_FAULT;
	endproperty
	a_ignore: assert property (p_ignore) else $error("trigger taken in fault");

	property p_and;
		combined_fault_reset_out_o == (watchdog_fault_out_o & undervoltage_reset_out_o);
	endproperty
	a_and: assert property (p_and) else $error("combined not AND");

	property p_close;
		st_q == ST_OPEN && rise && mon && !pin.undervoltage
			|=> st_q == ST_CLOSED && watchdog_fault_out_o;
	endproperty
	a_close: assert property (p_close) else $error("trigger did not close");

	property p_dpulse;
		st_q == ST_CLOSED && rise && mon && !pin.undervoltage
			|=> st_q == ST_FAULT && !watchdog_fault_out_o;
	endproperty
	a_dpulse: assert property (p_dpulse) else $error("double pulse missed");

	property p_hold;
		st_q == ST_FAULT && !pin.undervoltage && !hold_done |=> !watchdog_fault_out_o;
	endproperty
	a_hold: assert property (p_hold) else $error("fault released early");

	property p_uv;
		pin.undervoltage |=> st_q == ST_IDLE && to_q == 32'h0 && !undervoltage_reset_out_o;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage not reset");

	c_dp: cover property (st_q == ST_CLOSED && rise ##1 st_q == ST_FAULT);
	c_to: cover property (st_q == ST_OPEN && to_done && mon && !rise ##1 st_q == ST_FAULT);
	c_reopen: cover property (st_q == ST_CLOSED ##1 st_q == ST_OPEN);
endmodule : current_gated_window_watchdog
`default_nettype wire

// ==== test/trigger_model.sv ====
// monitored controller model driving the trigger pin
// assumes the bench calls kick at a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module trigger_model (
	// clock
	input wire logic clk_i,
	// trigger line
	output logic trigger_o
);
	// idles low like the pulled-down pin
	initial trigger_o = 1'b0;
	// one rising edge per call, high for hi cycles
	task automatic kick(input int hi);
		trigger_o <= 1'b1;
		repeat (hi) @(posedge clk_i);
		trigger_o <= 1'b0;
		@(posedge clk_i);
	endtask : kick
endmodule : trigger_model
`default_nettype wire

// ==== test/tb_current_gated_window_watchdog.sv ====
// self-checking bench of the current gated window watchdog
// assumes short window limits and the trigger model on the trigger pin
`timescale 1ns/1ps
`default_nettype none
module tb_current_gated_window_watchdog;
	import wdog_pkg::*;
	localparam logic [31:0] TO = 32'h0000003C;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic trig;
	logic [4:0] pv = 5'h00;
	logic [3:0] sel_v = 4'hF;
	pins_s pins;
	wb_req_s wb = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, wdo, uvo, cmb, irq_o;
	logic [33:0] notes[$];
	int n_errors = 0;
	int checks = 0;
	int n;
	assign pins = {trig, pv};
	always #12.5 clk_i = ~clk_i;
	current_gated_window_watchdog #(.TIMEOUT_CYC_P(TO), .DPULSE_CYC_P(32'h0000000A),
		.HOLD_CYC_P(32'h00000014)) uut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
		.wb_req_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .watchdog_fault_out_o(wdo),
		.undervoltage_reset_out_o(uvo), .combined_fault_reset_out_o(cmb), .irq_o(irq_o));
	trigger_model mcu (.clk_i(clk_i), .trigger_o(trig));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// read notes are taken off as their answers arrive
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb.we === 1'b0 && notes.size() > 0) begin
			check({cmb, irq_o, wb_dat_o}, notes.pop_front());
		end
	end
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sel_v, dat: d};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_errors++;
			report_and_stop();
		end
		wb <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic c, input logic q);
		notes.push_back({c, q, d});
		bus(1'b0, a, 32'h0);
	endtask : rd
	// pins: adjust low, adjust high, at activation, at deactivation, undervoltage
	task automatic pin(input logic [4:0] v);
		pv <= v;
		repeat (8) @(posedge clk_i);
	endtask : pin
	initial begin
		logic [3:0] r;
		void'($urandom(32'h23E9854B));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(A_STATE, 32'h61, 1'b1, 1'b0);
		rd(A_TIMEOUT, TO, 1'b1, 1'b0);
		rd(8'h20, 32'h0, 1'b1, 1'b0);
		bus(1'b1, A_STATE, 32'hFFFFFFFF);
		rd(A_STATE, 32'h61, 1'b1, 1'b0);
		r = 4'($urandom());
		bus(1'b1, A_MASK, {28'h0, r});
		rd(A_MASK, {28'h0, r}, 1'b1, 1'b0);
		// upper lanes only: the mask byte must keep its value
		sel_v = 4'hE;
		bus(1'b1, A_MASK, 32'hF);
		sel_v = 4'hF;
		rd(A_MASK, {28'h0, r}, 1'b1, 1'b0);
		bus(1'b1, A_MASK, 32'h0);
		$display("registers done");
		pin(5'b00100);
		rd(A_STATE, 32'h72, 1'b1, 1'b0);
		// a pulse shorter than two cycles is lost in the pin filter
		mcu.kick(4 + int'(r[1:0] % 3));
		repeat (3) @(posedge clk_i);
		rd(A_STATE, 32'h74, 1'b1, 1'b0);
		// falling edge lands in the reopened window and must not count
		mcu.kick(20);
		repeat (6) @(posedge clk_i);
		rd(A_STATE, 32'h72, 1'b1, 1'b0);
		mcu.kick(3);
		repeat (4) @(posedge clk_i);
		mcu.kick(3);
		repeat (4) @(posedge clk_i);
		pin(5'b00010);
		rd(A_STATE, 32'h48, 1'b0, 1'b0);
		check(34'(wdo), 34'h0);
		repeat (30) @(posedge clk_i);
		rd(A_STATE, 32'h61, 1'b1, 1'b0);
		$display("window done");
		pin(5'b00000);
		rd(A_STATE, 32'h61, 1'b1, 1'b0);
		pv <= 5'b00100;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wdo !== 1'b0 && n < 100);
		check(34'(n >= 61 && n <= 72), 34'h1);
		if (n >= 100) begin
			report_and_stop();
		end
		pin(5'b00101);
		rd(A_STATE, 32'h21, 1'b0, 1'b0);
		check(34'(uvo), 34'h0);
		pin(5'b10100);
		rd(A_STATE, 32'h61, 1'b1, 1'b0);
		bus(1'b1, A_STATUS, 32'hF);
		mcu.kick(2);
		repeat (6) @(posedge clk_i);
		rd(A_STATUS, 32'h0, 1'b1, 1'b0);
		$display("gating done");
		bus(1'b1, A_MASK, 32'h8);
		pin(5'b01000);
		rd(A_STATE, 32'h72, 1'b1, 1'b0);
		pin(5'b00010);
		rd(A_STATUS, 32'hC, 1'b1, 1'b1);
		bus(1'b1, A_MASK, 32'h0);
		rd(A_STATUS, 32'hC, 1'b1, 1'b0);
		bus(1'b1, A_STATUS, 32'hC);
		bus(1'b1, A_MASK, 32'h8);
		rd(A_STATUS, 32'h0, 1'b1, 1'b0);
		$display("interrupt done");
		report_and_stop();
	end
endmodule : tb_current_gated_window_watchdog
`default_nettype wire
